// ### pbcc_pkg.sv
// Package: register map, field layout and reset values of the PLL base clock control
package pbcc_pkg;

    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_IDX = 8'h5c;
    localparam logic [7:0] BW_IDX = 8'h5d;
    localparam logic [7:0] PROG_IDX = 8'h5e;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_RESET = 8'h2f;
    localparam logic [7:0] BW_RESET = 8'h00;
    localparam logic [3:0] MUL_RESET = 4'h6;
    localparam logic [3:0] VRS_RESET = 4'h6;

    // ------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------
    localparam int CTRL_IE_BIT = 7;
    localparam int CTRL_FLAG_BIT = 6;
    localparam int CTRL_ON_BIT = 5;
    localparam int CTRL_BCS_BIT = 4;
    localparam logic [3:0] CTRL_UNUSED_READ = 4'hf;

    // ------------------------------------------------------------
    // Bandwidth control register fields
    // ------------------------------------------------------------
    localparam int BW_AUTO_BIT = 7;
    localparam int BW_LOCK_BIT = 6;
    localparam int BW_ACQ_BIT = 5;
    localparam int BW_XLD_BIT = 4;
    localparam logic [3:0] BW_TEST_READ = 4'h0;

    // ------------------------------------------------------------
    // Programming register fields
    // ------------------------------------------------------------
    localparam int PROG_MUL_LSB = 4;
    localparam int PROG_VRS_LSB = 0;

    // ------------------------------------------------------------
    // Timing counts
    // ------------------------------------------------------------
    localparam logic [1:0] HOLD_EDGES = 2'h3;
    localparam logic [3:0] XLD_WINDOW_MULT = 4'h4;

endpackage

// ### pbcc_sync.sv
// Two-flop synchroniser for a group of level inputs
`timescale 1ns/10ps
module pbcc_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Levels
    input wire logic [W-1:0] d_in,
    output logic [W-1:0] q_out
);

    logic [W-1:0] meta_reg;
    logic [W-1:0] sync_reg;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_reg <= '0;
            sync_reg <= '0;
        end
        else
        begin
            meta_reg <= d_in;
            sync_reg <= meta_reg;
        end
    end

    assign q_out = sync_reg;

endmodule

// ### pbcc_clk_switch.sv
// Base clock source switch with hold-in-state transition and divide by two
`timescale 1ns/10ps
module pbcc_clk_switch (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Source edges and select
    input wire logic xtal_rise,
    input wire logic vco_rise,
    input wire logic sel,
    // Output
    output logic clk_out,
    output logic busy
);

    logic cur_sel_reg;
    logic out_reg;
    logic [1:0] xcnt_reg;
    logic [1:0] vcnt_reg;
    logic switching;
    logic src_rise;

    assign switching = (sel != cur_sel_reg);
    // VCO when select is one, crystal when zero
    assign src_rise = cur_sel_reg ? vco_rise : xtal_rise;

    // ------------------------------------------------------------
    // Transition control
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            xcnt_reg <= 2'h0;
            vcnt_reg <= 2'h0;
            cur_sel_reg <= 1'b0;
        end
        else if (!switching)
        begin
            xcnt_reg <= 2'h0;
            vcnt_reg <= 2'h0;
        end
        else if (xcnt_reg == pbcc_pkg::HOLD_EDGES && vcnt_reg == pbcc_pkg::HOLD_EDGES)
        begin
            cur_sel_reg <= sel;
            xcnt_reg <= 2'h0;
            vcnt_reg <= 2'h0;
        end
        else
        begin
            if (xtal_rise && xcnt_reg != pbcc_pkg::HOLD_EDGES)
            begin
                xcnt_reg <= xcnt_reg + 2'h1;
            end
            if (vco_rise && vcnt_reg != pbcc_pkg::HOLD_EDGES)
            begin
                vcnt_reg <= vcnt_reg + 2'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // Divide by two
    // ------------------------------------------------------------
    // Toggling only on whole source edges keeps each phase full length
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            out_reg <= 1'b0;
        end
        else if (!switching && src_rise)
        begin
            out_reg <= ~out_reg;
        end
    end

    assign clk_out = out_reg;
    assign busy = switching;

endmodule

// ### pbcc_top.sv
// PLL base clock control: AHB-Lite registers, lock flag, source select, crystal loss
//
// Overview of operation
// - Lock interrupt enable ignores writes and reads zero while manual mode.
// - Lock flag sets on every lock toggle in automatic mode; interrupt when flag and enable set.
// - Lock flag reads zero whenever manual bandwidth mode is selected.
// - A read of the control register clears the lock flag unless a lock toggle comes in the same cycle.
// - While base clock select is one, loop-on stays set and read-only.
// - Base clock select cannot set while loop-on is clear.
// - Base clock select forced zero when loop off or range field zero.
// - On select change, output holds for three crystal and three VCO edges.
// - Base clock output is the selected source divided by two, even duty.
// - Select one routes VCO, select zero routes crystal.
// - Reset sets loop-on, clears enable, flag and select.
// - Control register low four bits read as ones.
// - Mode bit: one automatic, zero manual; reset manual.
// - Lock indicator read-only in automatic, zero in manual, reset clear.
// - Tracking bit is status in automatic, writable control in manual.
// - Manual tracking value kept during automatic and restored afterwards.
// - Crystal loss works only with VCO selected; else reads zero.
// - Multiplier field gives N equal to value, zero treated as one.
// - Reset sets the multiplier field to six.
// - Programming register ignores writes while loop-on is one.
// - Range field write-protected while on; zero disables loop, clears select.
// - Reset sets the VCO range field to six.
//
// The AHB-Lite interface to the registers was left to the implementer.
`timescale 1ns/10ps
module pbcc_top (
    // Clock and reset
    input wire logic I_SYS_CLK,
    input wire logic I_RESET_N,
    // AHB-Lite slave
    input wire logic I_HSEL,
    input wire logic [31:0] I_HADDR,
    input wire logic [1:0] I_HTRANS,
    input wire logic I_HWRITE,
    input wire logic [2:0] I_HSIZE,
    input wire logic [31:0] I_HWDATA,
    input wire logic I_HREADY,
    output logic [31:0] O_HRDATA,
    output logic O_HREADYOUT,
    output logic O_HRESP,
    // Clock sources and analog status
    input wire logic I_CRYSTAL_CLOCK,
    input wire logic I_VCO_CLOCK,
    input wire logic I_LOCK_DETECT,
    input wire logic I_TRACK_DETECT,
    input wire logic I_OSCILLATOR_ENABLE_IN,
    // Outputs to analog loop and system integration
    output logic O_BASE_CLOCK_OUT,
    output logic O_CLOCKGEN_INTERRUPT,
    output logic O_LOOP_ENABLE,
    output logic O_AUTO_MODE,
    output logic O_TRACKING_CTRL,
    output logic [3:0] O_MULTIPLIER_N,
    output logic [3:0] O_VCO_RANGE
);

    typedef enum logic [1:0] {BUS_IDLE, BUS_WRITE, BUS_READ_CAPTURE, BUS_READ_DONE} pbcc_bus_t;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    pbcc_bus_t bus_reg;
    pbcc_bus_t bus_next;
    logic [7:0] idx_reg;
    logic accept;
    logic [7:0] wdata;
    logic wr_ctrl, wr_bw, wr_prog, rd_ctrl;
    logic [3:0] sync_out;
    logic xtal_s, vco_s, lock_s, track_s;
    logic xtal_d_reg, vco_d_reg, lock_d_reg;
    logic xtal_rise, vco_rise, lock_toggle;
    logic ie_reg, flag_reg, on_reg, bcs_reg;
    logic auto_reg, acq_reg, xld_reg;
    logic [5:0] xld_cnt_reg;
    logic [3:0] mul_reg, vrs_reg;
    logic irq_reg;
    logic out_en_reg;
    logic [31:0] rdata_reg;
    logic vrs_zero;
    logic [3:0] n_eff;
    logic [5:0] xld_window;
    logic [7:0] ctrl_read, bw_read, rd_value;
    logic sw_clk;

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    // Sources are sampled, so each must run below half the system clock
    pbcc_sync #(
        .W(4)
    ) u_sync (
        .clk(I_SYS_CLK),
        .rst_n(I_RESET_N),
        .d_in({I_TRACK_DETECT, I_LOCK_DETECT, I_VCO_CLOCK, I_CRYSTAL_CLOCK}),
        .q_out(sync_out)
    );

    assign xtal_s = sync_out[0];
    assign vco_s = sync_out[1];
    assign lock_s = sync_out[2];
    assign track_s = sync_out[3];

    always_ff @(posedge I_SYS_CLK or negedge I_RESET_N)
    begin
        if (!I_RESET_N)
        begin
            xtal_d_reg <= 1'b0;
            vco_d_reg <= 1'b0;
            lock_d_reg <= 1'b0;
        end
        else
        begin
            xtal_d_reg <= xtal_s;
            vco_d_reg <= vco_s;
            lock_d_reg <= lock_s;
        end
    end

    assign xtal_rise = xtal_s & ~xtal_d_reg;
    assign vco_rise = vco_s & ~vco_d_reg;
    assign lock_toggle = lock_s ^ lock_d_reg;

    // ------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------
    // Reads take one wait state so the data sees any write just before
    assign accept = I_HSEL & I_HTRANS[1] & I_HREADY;
    assign wdata = I_HWDATA[7:0];

    always_comb
    begin
        bus_next = bus_reg;
        unique case (bus_reg)
            BUS_IDLE, BUS_WRITE, BUS_READ_DONE:
            begin
                if (accept)
                    bus_next = I_HWRITE ? BUS_WRITE : BUS_READ_CAPTURE;
                else
                    bus_next = BUS_IDLE;
            end
            BUS_READ_CAPTURE:
                bus_next = BUS_READ_DONE;
        endcase
    end

    always_ff @(posedge I_SYS_CLK or negedge I_RESET_N)
    begin
        if (!I_RESET_N)
        begin
            bus_reg <= BUS_IDLE;
            idx_reg <= 8'h00;
        end
        else
        begin
            bus_reg <= bus_next;
            if (accept)
                idx_reg <= (I_HADDR[31:10] == 22'h0) ? I_HADDR[9:2] : 8'hff;
        end
    end

    assign O_HREADYOUT = (bus_reg != BUS_READ_CAPTURE);
    assign O_HRESP = 1'b0;
    assign wr_ctrl = (bus_reg == BUS_WRITE) && (idx_reg == pbcc_pkg::CTRL_IDX);
    assign wr_bw = (bus_reg == BUS_WRITE) && (idx_reg == pbcc_pkg::BW_IDX);
    assign wr_prog = (bus_reg == BUS_WRITE) && (idx_reg == pbcc_pkg::PROG_IDX);
    assign rd_ctrl = (bus_reg == BUS_READ_CAPTURE) && (idx_reg == pbcc_pkg::CTRL_IDX);

    // ------------------------------------------------------------
    // Read view
    // ------------------------------------------------------------
    always_comb
    begin
        ctrl_read = {ie_reg & auto_reg, flag_reg & auto_reg, on_reg, bcs_reg,
                     pbcc_pkg::CTRL_UNUSED_READ};
        bw_read = {auto_reg, lock_s & auto_reg, auto_reg ? track_s : acq_reg,
                   xld_reg & bcs_reg, pbcc_pkg::BW_TEST_READ};
        unique case (idx_reg)
            pbcc_pkg::CTRL_IDX: rd_value = ctrl_read;
            pbcc_pkg::BW_IDX: rd_value = bw_read;
            pbcc_pkg::PROG_IDX: rd_value = {mul_reg, vrs_reg};
            default: rd_value = 8'h00;
        endcase
    end

    always_ff @(posedge I_SYS_CLK or negedge I_RESET_N)
    begin
        if (!I_RESET_N)
            rdata_reg <= 32'h0;
        else if (bus_reg == BUS_READ_CAPTURE)
            rdata_reg <= {24'h0, rd_value};
    end

    assign O_HRDATA = rdata_reg;

    // ------------------------------------------------------------
    // Bandwidth mode and tracking control
    // ------------------------------------------------------------
    always_ff @(posedge I_SYS_CLK or negedge I_RESET_N)
    begin
        if (!I_RESET_N)
        begin
            auto_reg <= 1'b0;
            acq_reg <= 1'b0;
        end
        else if (wr_bw)
        begin
            auto_reg <= wdata[pbcc_pkg::BW_AUTO_BIT];
            if (!auto_reg)
            begin
                // Shadow is only touched in manual mode
                acq_reg <= wdata[pbcc_pkg::BW_ACQ_BIT];
            end
        end
    end

    // ------------------------------------------------------------
    // Interrupt enable and lock flag
    // ------------------------------------------------------------
    always_ff @(posedge I_SYS_CLK or negedge I_RESET_N)
    begin
        if (!I_RESET_N)
            ie_reg <= 1'b0;
        else if (!auto_reg)
            ie_reg <= 1'b0;
        else if (wr_ctrl)
            ie_reg <= wdata[pbcc_pkg::CTRL_IE_BIT];
    end

    // A toggle in the same cycle as the clearing read wins
    always_ff @(posedge I_SYS_CLK or negedge I_RESET_N)
    begin
        if (!I_RESET_N)
            flag_reg <= 1'b0;
        else if (!auto_reg)
            flag_reg <= 1'b0;
        else if (lock_toggle)
            flag_reg <= 1'b1;
        else if (rd_ctrl)
            flag_reg <= 1'b0;
    end

    always_ff @(posedge I_SYS_CLK or negedge I_RESET_N)
    begin
        if (!I_RESET_N)
            irq_reg <= 1'b0;
        else
            irq_reg <= flag_reg & ie_reg & auto_reg;
    end

    // ------------------------------------------------------------
    // Loop on and base clock select
    // ------------------------------------------------------------
    assign vrs_zero = (vrs_reg == 4'h0);

    // Old select value holds the loop on through a deselecting write
    always_ff @(posedge I_SYS_CLK or negedge I_RESET_N)
    begin
        if (!I_RESET_N)
            on_reg <= 1'b1;
        else if (wr_ctrl)
            on_reg <= wdata[pbcc_pkg::CTRL_ON_BIT] | bcs_reg;
    end

    always_ff @(posedge I_SYS_CLK or negedge I_RESET_N)
    begin
        if (!I_RESET_N)
            bcs_reg <= 1'b0;
        else if (!on_reg || vrs_zero)
            bcs_reg <= 1'b0;
        else if (wr_ctrl)
        begin
            // Old loop-on value, so one write cannot turn on and select
            bcs_reg <= wdata[pbcc_pkg::CTRL_BCS_BIT] & on_reg;
        end
    end

    pbcc_clk_switch u_switch (
        .clk(I_SYS_CLK),
        .rst_n(I_RESET_N),
        .xtal_rise(xtal_rise),
        .vco_rise(vco_rise),
        .sel(bcs_reg),
        .clk_out(sw_clk),
        .busy()
    );

    // ------------------------------------------------------------
    // Programming register
    // ------------------------------------------------------------
    always_ff @(posedge I_SYS_CLK or negedge I_RESET_N)
    begin
        if (!I_RESET_N)
        begin
            mul_reg <= pbcc_pkg::MUL_RESET;
            vrs_reg <= pbcc_pkg::VRS_RESET;
        end
        else if (wr_prog && !on_reg)
        begin
            mul_reg <= wdata[pbcc_pkg::PROG_MUL_LSB +: 4];
            vrs_reg <= wdata[pbcc_pkg::PROG_VRS_LSB +: 4];
        end
    end

    assign n_eff = (mul_reg == 4'h0) ? 4'h1 : mul_reg;

    // ------------------------------------------------------------
    // Crystal loss detection
    // ------------------------------------------------------------
    // Window of four times N VCO edges; any crystal edge inside clears loss
    assign xld_window = {2'h0, n_eff} * {2'h0, pbcc_pkg::XLD_WINDOW_MULT};

    always_ff @(posedge I_SYS_CLK or negedge I_RESET_N)
    begin
        if (!I_RESET_N)
        begin
            xld_reg <= 1'b0;
            xld_cnt_reg <= 6'h0;
        end
        else if (!bcs_reg)
        begin
            xld_reg <= 1'b0;
            xld_cnt_reg <= 6'h0;
        end
        else if (wr_bw)
        begin
            xld_reg <= wdata[pbcc_pkg::BW_XLD_BIT];
            xld_cnt_reg <= wdata[pbcc_pkg::BW_XLD_BIT] ? xld_window : 6'h0;
        end
        else if (xld_cnt_reg != 6'h0)
        begin
            if (xtal_rise)
            begin
                xld_reg <= 1'b0;
                xld_cnt_reg <= 6'h0;
            end
            else if (vco_rise)
                xld_cnt_reg <= xld_cnt_reg - 6'h1;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Loop enable needs the oscillator enable and a non-zero range
    always_ff @(posedge I_SYS_CLK or negedge I_RESET_N)
    begin
        if (!I_RESET_N)
            out_en_reg <= 1'b0;
        else
            out_en_reg <= on_reg & ~vrs_zero & I_OSCILLATOR_ENABLE_IN;
    end

    assign O_BASE_CLOCK_OUT = sw_clk;
    assign O_CLOCKGEN_INTERRUPT = irq_reg;
    assign O_LOOP_ENABLE = out_en_reg;
    assign O_AUTO_MODE = auto_reg;
    assign O_TRACKING_CTRL = acq_reg;
    assign O_MULTIPLIER_N = n_eff;
    assign O_VCO_RANGE = vrs_reg;

endmodule

// ### pbcc_chk.sv
// Checker: port-level assertions for the PLL base clock control
`timescale 1ns/10ps
module pbcc_chk (
    // Clock and reset
    input wire logic I_SYS_CLK,
    input wire logic I_RESET_N,
    // Watched outputs
    input wire logic O_BASE_CLOCK_OUT,
    input wire logic O_CLOCKGEN_INTERRUPT,
    input wire logic O_LOOP_ENABLE,
    input wire logic O_AUTO_MODE,
    input wire logic O_TRACKING_CTRL,
    input wire logic [3:0] O_MULTIPLIER_N,
    input wire logic [3:0] O_VCO_RANGE
);
    // --------------------
    // Assertions
    // --------------------
    default clocking cb @(posedge I_SYS_CLK);
    endclocking
    default disable iff (!I_RESET_N);
    // Eight is below the shortest source period, so any cut phase shows
    sequence hi_run;
        O_BASE_CLOCK_OUT [*8];
    endsequence
    sequence lo_run;
        !O_BASE_CLOCK_OUT [*8];
    endsequence
    hi_phase_a: assert property (
        $rose(O_BASE_CLOCK_OUT) |-> hi_run)
        else $error("base clock high phase cut short");
    lo_phase_a: assert property (
        $fell(O_BASE_CLOCK_OUT) |-> lo_run)
        else $error("base clock low phase cut short");
    reset_vals_a: assert property (
        $rose(I_RESET_N) |-> O_MULTIPLIER_N == 4'h6 && O_VCO_RANGE == 4'h6)
        else $error("multiplier or range not six after reset");
    irq_manual_a: assert property (
        !O_AUTO_MODE |=> !O_CLOCKGEN_INTERRUPT)
        else $error("interrupt raised in manual mode");
    mult_nonzero_a: assert property (
        O_MULTIPLIER_N != 4'h0)
        else $error("multiplier shown as zero");
    prog_locked_a: assert property (
        O_LOOP_ENABLE |-> $stable(O_MULTIPLIER_N) && $stable(O_VCO_RANGE))
        else $error("programming changed while loop on");
    range_off_a: assert property (
        O_VCO_RANGE == 4'h0 |=> !O_LOOP_ENABLE)
        else $error("loop enabled with zero range");
    track_keep_a: assert property (
        O_AUTO_MODE && $past(O_AUTO_MODE) |-> $stable(O_TRACKING_CTRL))
        else $error("tracking store changed in automatic mode");
endmodule

bind pbcc_top pbcc_chk chk_u (
    .I_SYS_CLK(I_SYS_CLK),
    .I_RESET_N(I_RESET_N),
    .O_BASE_CLOCK_OUT(O_BASE_CLOCK_OUT),
    .O_CLOCKGEN_INTERRUPT(O_CLOCKGEN_INTERRUPT),
    .O_LOOP_ENABLE(O_LOOP_ENABLE),
    .O_AUTO_MODE(O_AUTO_MODE),
    .O_TRACKING_CTRL(O_TRACKING_CTRL),
    .O_MULTIPLIER_N(O_MULTIPLIER_N),
    .O_VCO_RANGE(O_VCO_RANGE)
);

// ### pbcc_sim_model.sv
// Partner model: system integration side, clock sources and base clock meter
`timescale 1ns/10ps
module pbcc_sim_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Base clock and crystal stop
    input wire logic base_clk,
    input wire logic xtal_stop,
    // Sources and enable
    output logic xtal_clk,
    output logic vco_clk,
    output logic osc_en,
    // Last base clock period in system cycles
    output int period
);
    // --------------------
    // Sources and meter
    // --------------------
    int xc = 0;
    int vc = 0;
    int pc = 0;
    logic base_q = 1'b0;
    initial
    begin
        xtal_clk = 1'b0;
        vco_clk = 1'b0;
        period = 0;
    end
    assign osc_en = 1'b1;
    // Crystal period 16 cycles, VCO 12; a stopped crystal rests low
    always @(posedge clk)
    begin
        xc <= (xc + 1) % 8;
        vc <= (vc + 1) % 6;
        if (xc == 0)
            xtal_clk <= ~xtal_clk & ~xtal_stop;
        if (vc == 0)
            vco_clk <= ~vco_clk;
        base_q <= base_clk;
        pc <= (base_clk && !base_q) ? 1 : pc + 1;
        if (base_clk && !base_q)
            period <= pc;
    end
endmodule

// ### pll_base_clock_control_test.sv
// Testbench: register protection, lock flag, source switch and crystal loss
`timescale 1ns/10ps
module pll_base_clock_control_test;
    localparam logic [7:0] C = pbcc_pkg::CTRL_IDX;
    localparam logic [7:0] B = pbcc_pkg::BW_IDX;
    localparam logic [7:0] P = pbcc_pkg::PROG_IDX;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic lock_det = 1'b0;
    logic trk_det = 1'b0;
    logic xtal_stop = 1'b0;
    logic [7:0] rd;
    wire logic [31:0] hrdata;
    wire logic hready, xtal, vco, osc_en, base, irq, loop_en, auto_m, trk, hresp;
    wire logic [3:0] mul_n;
    int period;
    int num_errors = 0;
    int samples_checked = 0;
    always #25 clk = ~clk;
    pbcc_top dut_u (
        .I_SYS_CLK(clk), .I_RESET_N(rst_n), .I_HSEL(hsel), .I_HADDR(haddr),
        .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(3'h2), .I_HWDATA(hwdata),
        .I_HREADY(hready), .O_HRDATA(hrdata), .O_HREADYOUT(hready), .O_HRESP(hresp),
        .I_CRYSTAL_CLOCK(xtal), .I_VCO_CLOCK(vco), .I_LOCK_DETECT(lock_det),
        .I_TRACK_DETECT(trk_det), .I_OSCILLATOR_ENABLE_IN(osc_en),
        .O_BASE_CLOCK_OUT(base), .O_CLOCKGEN_INTERRUPT(irq), .O_LOOP_ENABLE(loop_en),
        .O_AUTO_MODE(auto_m), .O_TRACKING_CTRL(trk), .O_MULTIPLIER_N(mul_n),
        .O_VCO_RANGE()
    );
    pbcc_sim_model sim_u (
        .clk(clk), .rst_n(rst_n), .base_clk(base), .xtal_stop(xtal_stop),
        .xtal_clk(xtal), .vco_clk(vco), .osc_en(osc_en), .period(period)
    );
    // --------------------
    // Tasks
    // --------------------
    task automatic complete_run;
        $display("mismatches %0d comparisons %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
            num_errors++;
        end
    endtask
    // Looked at on the falling edge: the value the next rising edge samples
    task automatic ready_wait;
        int n = 0;
        do
        begin
            @(negedge clk);
            n++;
        end
        while (hready !== 1'b1 && n < 40);
        rd = hrdata[7:0];
        if (hready !== 1'b1)
        begin
            num_errors++;
            complete_run;
        end
        @(posedge clk);
    endtask
    // One single transfer; a read compares against d
    task automatic acc(input logic [7:0] idx, input logic wr, input logic [7:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {22'h0, idx, 2'h0};
        hwrite <= wr;
        ready_wait;
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        ready_wait;
        if (!wr)
            chk(rd, d);
        chk({7'h0, hresp}, 8'h00);
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask
    // --------------------
    // Sequence
    // --------------------
    initial
    begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        acc(C, 1'b0, pbcc_pkg::CTRL_RESET);
        acc(B, 1'b0, pbcc_pkg::BW_RESET);
        acc(P, 1'b0, 8'h66);
        chk({7'h0, loop_en}, 8'h01);
        acc(8'h40, 1'b0, 8'h00);
        acc(P, 1'b1, 8'h35);
        acc(P, 1'b0, 8'h66);
        idle(150);
        chk(period[7:0], 8'h20);
        acc(C, 1'b1, 8'h30);
        idle(150);
        chk(period[7:0], 8'h18);
        xtal_stop <= 1'b1;
        idle(20);
        acc(B, 1'b1, 8'h10);
        idle(320);
        acc(B, 1'b0, 8'h10);
        xtal_stop <= 1'b0;
        acc(B, 1'b1, 8'h10);
        idle(320);
        acc(B, 1'b0, 8'h00);
        acc(C, 1'b1, 8'h00);
        acc(C, 1'b0, 8'h2f);
        acc(B, 1'b0, 8'h00);
        acc(C, 1'b1, 8'h00);
        acc(C, 1'b1, 8'h10);
        acc(C, 1'b0, 8'h0f);
        acc(C, 1'b1, 8'h30);
        acc(C, 1'b0, 8'h2f);
        acc(C, 1'b1, 8'h00);
        acc(P, 1'b1, 8'h00);
        idle(2);
        chk({4'h0, mul_n}, 8'h01);
        acc(C, 1'b1, 8'h20);
        acc(C, 1'b1, 8'h30);
        acc(C, 1'b0, 8'h2f);
        idle(2);
        chk({7'h0, loop_en}, 8'h00);
        acc(C, 1'b1, 8'h00);
        acc(P, 1'b1, 8'h66);
        acc(C, 1'b1, 8'h20);
        acc(B, 1'b1, 8'ha0);
        acc(B, 1'b0, 8'h80);
        chk({7'h0, auto_m}, 8'h01);
        chk({7'h0, trk}, 8'h01);
        acc(C, 1'b1, 8'ha0);
        lock_det <= 1'b1;
        trk_det <= 1'b1;
        idle(10);
        chk({7'h0, irq}, 8'h01);
        acc(B, 1'b0, 8'he0);
        acc(C, 1'b0, 8'hef);
        acc(C, 1'b0, 8'haf);
        idle(3);
        chk({7'h0, irq}, 8'h00);
        acc(B, 1'b1, 8'h00);
        acc(B, 1'b0, 8'h20);
        acc(C, 1'b0, 8'h2f);
        lock_det <= 1'b0;
        idle(10);
        acc(C, 1'b0, 8'h2f);
        acc(C, 1'b1, 8'ha0);
        acc(B, 1'b1, 8'h80);
        acc(C, 1'b0, 8'h2f);
        complete_run;
    end
endmodule
